/* bcr_pkg.sv */
`default_nettype none

package bcr_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [14:0] ADDR_CLOCK_CONTROL = 15'h7ff8;
  localparam logic [14:0] ADDR_SECONDS_AND_HALT = 15'h7ff9;
  localparam logic [14:0] ADDR_MINUTES = 15'h7ffa;
  localparam logic [14:0] ADDR_HOURS = 15'h7ffb;
  localparam logic [14:0] ADDR_CENTURY_AND_WEEKDAY = 15'h7ffc;
  localparam logic [14:0] ADDR_DAY_OF_MONTH = 15'h7ffd;
  localparam logic [14:0] ADDR_MONTH = 15'h7ffe;
  localparam logic [14:0] ADDR_YEAR = 15'h7fff;
  localparam logic [11:0] ADDR_CLOCK_PAGE = 12'hfff;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTRL_WRITE_HOLD = 7;
  localparam int CTRL_READ_HOLD = 6;
  localparam int CTRL_CAL_SIGN = 5;
  localparam int CTRL_CAL_MSB = 4;
  localparam int SEC_OSCILLATOR_HALT = 7;
  localparam int DAY_FREQ_TEST_ENABLE = 6;
  localparam int DAY_CENTURY_TOGGLE_ENABLE = 5;
  localparam int DAY_CENTURY_FLAG = 4;
  localparam int DAY_WEEKDAY_MSB = 2;

  // Bits that must stay zero are cleared on write.
  localparam logic [7:0] MASK_SECONDS = 8'h7f;
  localparam logic [7:0] MASK_MINUTES = 8'h7f;
  localparam logic [7:0] MASK_HOURS = 8'h3f;
  localparam logic [7:0] MASK_DAY_OF_MONTH = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  localparam logic [7:0] MASK_YEAR = 8'hff;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_CLOCK_CONTROL = 8'h00;
  localparam logic RST_OSCILLATOR_HALT = 1'b1;
  localparam logic RST_FREQ_TEST_ENABLE = 1'b0;
  localparam logic RST_CENTURY_TOGGLE_ENABLE = 1'b0;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int OSC_HZ = 32768;
  localparam int STAGE_DIV = 256;
  localparam int FTEST_HZ = 512;
  localparam int CAL_CYCLE_MINUTES = 64;
  localparam int CAL_ELIGIBLE_MINUTES = 62;
  localparam logic [9:0] STAGE_NORMAL = 10'(STAGE_DIV);
  localparam logic [9:0] CAL_SHORTEN = 10'h080;
  localparam logic [9:0] CAL_LENGTHEN = 10'h100;
  localparam logic [9:0] STAGE_NEGATIVE = 10'(STAGE_NORMAL - CAL_SHORTEN);
  localparam logic [9:0] STAGE_POSITIVE = 10'(STAGE_NORMAL + CAL_LENGTHEN);
  localparam logic [6:0] STAGE_LAST = 7'(OSC_HZ / STAGE_DIV - 1);
  localparam logic [5:0] CAL_MIN_LAST = 6'(CAL_CYCLE_MINUTES - 1);
  localparam logic [5:0] CAL_MIN_LIMIT = 6'(CAL_ELIGIBLE_MINUTES);
  localparam int FTEST_BIT = $clog2(OSC_HZ / FTEST_HZ) - 1;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic century_flag;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day_of_month;
    logic [7:0] weekday;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } bcr_time_t;

  localparam bcr_time_t RST_TIME = '{century_flag: 1'b0, year: 8'h00, month: 8'h01,
                                     day_of_month: 8'h01, weekday: 8'h01, hours: 8'h00,
                                     minutes: 8'h00, seconds: 8'h00};

  function automatic logic [7:0] bcr_bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {4'(v[7:4] + 4'h1), 4'h0};
    end
    return {v[7:4], 4'(v[3:0] + 4'h1)};
  endfunction

endpackage

`default_nettype wire

/* bcr_cal_divider.sv */
`timescale 1ns/1ns
`default_nettype none

module bcr_cal_divider (
  input wire logic clk_i,          // System clock.
  input wire logic resetn_i,       // Asynchronous reset, active low.
  input wire logic tick_i,         // Oscillator cycle, already gated by halt.
  input wire logic restart_i,      // Restart the second after a counter load.
  input wire logic [4:0] cal_mag_i, // Calibration magnitude.
  input wire logic cal_pos_i,      // Calibration direction, 1 is positive.
  input wire logic last_sec_i,     // Running seconds stand at 59.
  output logic sec_pulse_o,        // One-cycle pulse per second.
  output logic ftest_o             // Uncalibrated 512 Hz square wave.
);

  typedef struct packed {
    logic [9:0] stage_cnt;
    logic [9:0] stage_lim;
    logic [6:0] sub_cnt;
    logic [5:0] cyc_min;
    logic [5:0] ftest_cnt;
    logic sec_pulse;
  } bcr_div_state_t;

  bcr_div_state_t st;
  bcr_div_state_t next_st;
  logic [5:0] new_min;
  logic eligible;

  always_comb begin
    next_st = st;
    next_st.sec_pulse = 1'b0;
    new_min = 6'(st.cyc_min + 6'h01);
    // first 2N minutes
    // The index wraps to 0 after minute 63, so minute 0 of each later cycle is corrected as well.
    eligible = (new_min < bcr_pkg::CAL_MIN_LIMIT) && (new_min < {cal_mag_i, 1'b0});
    if (restart_i) begin
      next_st.stage_cnt = 10'h000;
      next_st.sub_cnt = 7'h00;
      next_st.stage_lim = bcr_pkg::STAGE_NORMAL;
    end else if (tick_i) begin
      next_st.ftest_cnt = 6'(st.ftest_cnt + 6'h01);
      if (st.stage_cnt == 10'(st.stage_lim - 10'h001)) begin
        next_st.stage_cnt = 10'h000;
        next_st.stage_lim = bcr_pkg::STAGE_NORMAL;
        if (st.sub_cnt == bcr_pkg::STAGE_LAST) begin
          next_st.sub_cnt = 7'h00;
          next_st.sec_pulse = 1'b1;
          if (last_sec_i) begin
            next_st.cyc_min = (st.cyc_min == bcr_pkg::CAL_MIN_LAST) ? 6'h00 : new_min;
            if (eligible) begin
              next_st.stage_lim = cal_pos_i ? bcr_pkg::STAGE_POSITIVE : bcr_pkg::STAGE_NEGATIVE;
            end
          end
        end else begin
          next_st.sub_cnt = 7'(st.sub_cnt + 7'h01);
        end
      end else begin
        next_st.stage_cnt = 10'(st.stage_cnt + 10'h001);
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '{stage_cnt: 10'h000, stage_lim: bcr_pkg::STAGE_NORMAL, sub_cnt: 7'h00,
              cyc_min: 6'h00, ftest_cnt: 6'h00, sec_pulse: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign sec_pulse_o = st.sec_pulse;
  assign ftest_o = st.ftest_cnt[bcr_pkg::FTEST_BIT];

endmodule

`default_nettype wire

/* bcr_time_counter.sv */
`timescale 1ns/1ns
`default_nettype none

module bcr_time_counter (
  input wire logic clk_i,                    // System clock.
  input wire logic resetn_i,                 // Asynchronous reset, active low.
  input wire logic sec_pulse_i,              // Advance by one second.
  input wire logic load_i,                   // Load all counters at once.
  input wire bcr_pkg::bcr_time_t load_val_i, // Values to load.
  input wire logic century_toggle_enable_i,  // Allow the century flag to toggle.
  output bcr_pkg::bcr_time_t time_o          // Running counters.
);

  bcr_pkg::bcr_time_t st;
  bcr_pkg::bcr_time_t next_st;
  logic [7:0] month_end;

  // Last day of the month in BCD; years divisible by four are leap years.
  function automatic logic [7:0] days_in_month(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[1:0] == 2'b00 && y[3:0] != 4'h2);
    leap = leap && (y[4] || y[3:0] != 4'h6);
    case (m)
      8'h02: days_in_month = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in_month = 8'h30;
      default: days_in_month = 8'h31;
    endcase
  endfunction

  always_comb begin
    next_st = st;
    month_end = days_in_month(st.month, st.year);
    if (load_i) begin
      next_st = load_val_i;
    end else if (sec_pulse_i) begin
      next_st.seconds = bcr_pkg::bcr_bcd_inc(st.seconds);
      if (st.seconds == 8'h59) begin
        next_st.seconds = 8'h00;
        next_st.minutes = bcr_pkg::bcr_bcd_inc(st.minutes);
        if (st.minutes == 8'h59) begin
          next_st.minutes = 8'h00;
          next_st.hours = bcr_pkg::bcr_bcd_inc(st.hours);
          if (st.hours == 8'h23) begin
            next_st.hours = 8'h00;
            next_st.weekday = (st.weekday == 8'h07) ? 8'h01 : bcr_pkg::bcr_bcd_inc(st.weekday);
            next_st.day_of_month = bcr_pkg::bcr_bcd_inc(st.day_of_month);
            if (st.day_of_month == month_end) begin
              next_st.day_of_month = 8'h01;
              next_st.month = bcr_pkg::bcr_bcd_inc(st.month);
              if (st.month == 8'h12) begin
                next_st.month = 8'h01;
                next_st.year = bcr_pkg::bcr_bcd_inc(st.year);
                if (st.year == 8'h99) begin
                  next_st.year = 8'h00;
                  if (century_toggle_enable_i) begin
                    next_st.century_flag = ~st.century_flag;
                  end
                end
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= bcr_pkg::RST_TIME;
    end else begin
      st <= next_st;
    end
  end

  assign time_o = st;

endmodule

`default_nettype wire

/* bcr_clock_regs.sv */
// Operation
// - Seconds bit 7 is oscillator halt; writing 1 stops it at any time.
// - Clearing halt restarts the oscillator within one second.
// - Oscillator halt is set when the part comes out of reset.
// - Time registers are BCD, tens high nibble, within documented ranges.
// - With toggle enable set, century flag inverts at each century rollover.
// - Century toggle enable accepts writes regardless of write-hold.
// - 32768 Hz source divided down; calibration acts at divide-by-256 stage.
// - Control bits 4..0 hold calibration magnitude 0 to 31.
// - Control bit 5 selects direction; 1 positive, 0 negative.
// - 64-minute cycle; first 62 minutes eligible, one second per minute.
// - Corrected second is 128 cycles shorter or 256 cycles longer.
// - Magnitude N corrects the first 2N minutes of each cycle.
// - Test enable and running oscillator toggle data bit zero at 512 Hz.
// - Test output rate ignores calibration settings.
// - Host clears test enable; device clears it on power-down.
// - Read-hold freezes visible registers; updates resume within one second.
// - Write-hold freezes updates; release loads counters, update within one second.
`timescale 1ns/1ns
`default_nettype none

module bcr_clock_regs (
  input wire logic clk_i,          // System clock, 250 MHz.
  input wire logic resetn_i,       // Asynchronous reset, active low.
  input wire logic ce_n_i,         // Chip enable, active low.
  input wire logic oe_n_i,         // Output enable, active low.
  input wire logic we_n_i,         // Write enable, active low.
  input wire logic [14:0] addr_i,  // Byte address.
  input wire logic [7:0] data_i,   // Write data from the bus.
  input wire logic osc_tick_i,     // One pulse per 32768 Hz oscillator cycle.
  input wire logic power_down_i,   // Supply is going down.
  output logic [7:0] data_o,       // Read data to the bus.
  output logic data_oe_o           // Read data is driven.
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    bcr_pkg::bcr_time_t vis;
    logic [7:0] clock_control;
    logic oscillator_halt;
    logic freq_test_enable;
    logic century_toggle_enable;
    logic wr_act;
    logic [14:0] wr_addr;
    logic [7:0] wr_data;
    logic update;
    logic load;
    logic [7:0] dout;
    logic doe;
  } bcr_regs_state_t;

  bcr_regs_state_t st;
  bcr_regs_state_t next_st;

  bcr_pkg::bcr_time_t run_time;
  logic sec_pulse;
  logic ftest;
  logic osc_run_tick;
  logic bus_write;
  logic bus_read;
  logic wr_commit;
  logic whold;
  logic rhold;

  // ------------------------------------------------------------------
  // Register read view
  // ------------------------------------------------------------------
  function automatic logic [7:0] read_view(input bcr_regs_state_t s, input logic [2:0] idx,
                                           input logic test_bit);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      3'h0: v = s.clock_control;
      3'h1: begin
        v = {s.oscillator_halt, s.vis.seconds[6:0]};
        // 512 Hz on data bit zero
        if (s.freq_test_enable && !s.oscillator_halt) begin
          v[0] = test_bit;
        end
      end
      3'h2: v = s.vis.minutes;
      3'h3: v = s.vis.hours;
      3'h4: begin
        v = s.vis.weekday;
        v[bcr_pkg::DAY_FREQ_TEST_ENABLE] = s.freq_test_enable;
        v[bcr_pkg::DAY_CENTURY_TOGGLE_ENABLE] = s.century_toggle_enable;
        v[bcr_pkg::DAY_CENTURY_FLAG] = s.vis.century_flag;
      end
      3'h5: v = s.vis.day_of_month;
      3'h6: v = s.vis.month;
      3'h7: v = s.vis.year;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ------------------------------------------------------------------
  // Oscillator gate and divider
  // ------------------------------------------------------------------
  // halt gates the oscillator
  assign osc_run_tick = osc_tick_i && !st.oscillator_halt;

  assign whold = st.clock_control[bcr_pkg::CTRL_WRITE_HOLD];
  assign rhold = st.clock_control[bcr_pkg::CTRL_READ_HOLD];

  bcr_cal_divider u_div (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .tick_i(osc_run_tick),
    .restart_i(st.load),
    .cal_mag_i(st.clock_control[bcr_pkg::CTRL_CAL_MSB:0]),
    .cal_pos_i(st.clock_control[bcr_pkg::CTRL_CAL_SIGN]),
    .last_sec_i(run_time.seconds == 8'h59),
    .sec_pulse_o(sec_pulse),
    .ftest_o(ftest)
  );

  // The counters keep running under both holds; only the copy is frozen.
  bcr_time_counter u_cnt (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .sec_pulse_i(sec_pulse),
    .load_i(st.load),
    .load_val_i(st.vis),
    .century_toggle_enable_i(st.century_toggle_enable),
    .time_o(run_time)
  );

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  // Writes are committed at the end of the strobe, from the last sampled
  // address and data, so data settling late in the cycle is still caught.
  assign bus_write = !ce_n_i && !we_n_i;
  assign bus_read = !ce_n_i && !oe_n_i && we_n_i && (addr_i[14:3] == bcr_pkg::ADDR_CLOCK_PAGE);
  assign wr_commit = st.wr_act && !bus_write && (st.wr_addr[14:3] == bcr_pkg::ADDR_CLOCK_PAGE);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.load = 1'b0;
    next_st.update = sec_pulse;
    next_st.wr_act = bus_write;
    if (bus_write) begin
      next_st.wr_addr = addr_i;
      next_st.wr_data = data_i;
    end

    // write-hold freezes the copy
    // A counter load in flight must not be replaced by a stale copy of the counters.
    if (st.update && !whold && !rhold && !st.load) begin
      next_st.vis = run_time;
    end

    if (wr_commit) begin
      case (st.wr_addr)
        bcr_pkg::ADDR_CLOCK_CONTROL: begin
          next_st.clock_control = st.wr_data;
          if (whold && !st.wr_data[bcr_pkg::CTRL_WRITE_HOLD]) begin
            next_st.load = 1'b1;
          end
        end
        bcr_pkg::ADDR_SECONDS_AND_HALT: begin
          next_st.oscillator_halt = st.wr_data[bcr_pkg::SEC_OSCILLATOR_HALT];
          next_st.vis.seconds = st.wr_data & bcr_pkg::MASK_SECONDS;
        end
        bcr_pkg::ADDR_MINUTES: begin
          next_st.vis.minutes = st.wr_data & bcr_pkg::MASK_MINUTES;
        end
        bcr_pkg::ADDR_HOURS: begin
          next_st.vis.hours = st.wr_data & bcr_pkg::MASK_HOURS;
        end
        bcr_pkg::ADDR_CENTURY_AND_WEEKDAY: begin
          next_st.freq_test_enable = st.wr_data[bcr_pkg::DAY_FREQ_TEST_ENABLE];
          next_st.century_toggle_enable = st.wr_data[bcr_pkg::DAY_CENTURY_TOGGLE_ENABLE];
          if (whold) begin
            next_st.vis.century_flag = st.wr_data[bcr_pkg::DAY_CENTURY_FLAG];
          end
          next_st.vis.weekday = {5'h00, st.wr_data[bcr_pkg::DAY_WEEKDAY_MSB:0]};
        end
        bcr_pkg::ADDR_DAY_OF_MONTH: begin
          next_st.vis.day_of_month = st.wr_data & bcr_pkg::MASK_DAY_OF_MONTH;
        end
        bcr_pkg::ADDR_MONTH: begin
          next_st.vis.month = st.wr_data & bcr_pkg::MASK_MONTH;
        end
        bcr_pkg::ADDR_YEAR: begin
          next_st.vis.year = st.wr_data & bcr_pkg::MASK_YEAR;
        end
        default: begin
          next_st.vis = next_st.vis;
        end
      endcase
    end

    if (power_down_i) begin
      next_st.freq_test_enable = 1'b0;
    end

    next_st.doe = bus_read;
    next_st.dout = bus_read ? read_view(st, addr_i[2:0], ftest) : 8'h00;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st.vis <= bcr_pkg::RST_TIME;
      st.clock_control <= bcr_pkg::RST_CLOCK_CONTROL;
      st.oscillator_halt <= bcr_pkg::RST_OSCILLATOR_HALT;
      st.freq_test_enable <= bcr_pkg::RST_FREQ_TEST_ENABLE;
      st.century_toggle_enable <= bcr_pkg::RST_CENTURY_TOGGLE_ENABLE;
      st.wr_act <= 1'b0;
      st.wr_addr <= 15'h0000;
      st.wr_data <= 8'h00;
      st.update <= 1'b0;
      st.load <= 1'b0;
      st.dout <= 8'h00;
      st.doe <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign data_o = st.dout;
  assign data_oe_o = st.doe;

endmodule

`default_nettype wire

/* bcr_clock_regs_checker.sv */
`timescale 1ns/1ns
`default_nettype none

module bcr_clock_regs_checker (
  input wire logic clk_i,         // Clock.
  input wire logic resetn_i,      // Reset, active low.
  input wire logic ce_n_i,        // Chip enable, active low.
  input wire logic oe_n_i,        // Output enable, active low.
  input wire logic we_n_i,        // Write enable, active low.
  input wire logic [14:0] addr_i, // Address.
  input wire logic [7:0] data_i,  // Write data.
  input wire logic osc_tick_i,    // Oscillator tick.
  input wire logic power_down_i,  // Power going down.
  input wire logic [7:0] data_o,  // Read data.
  input wire logic data_oe_o      // Read data driven.
);
  logic rd;
  logic page;
  logic [14:0] ra;
  assign rd = !ce_n_i && !oe_n_i && we_n_i;
  assign page = addr_i[14:3] == bcr_pkg::ADDR_CLOCK_PAGE;
  // The address of the last sampled request tells which register data_o shows.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ra <= 15'h0000;
    end else begin
      ra <= addr_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_read_answered: assert property (rd && page |=> data_oe_o) else $error("read not answered");
  a_unmapped_silent: assert property (rd && !page |=> !data_oe_o) else $error("unmapped read answered");
  a_deselect_quiet: assert property ((ce_n_i || oe_n_i || !we_n_i) |=> !data_oe_o)
    else $error("output kept after deselect");
  a_test_cleared: assert property (power_down_i && (ce_n_i || we_n_i) ##1 (ce_n_i || we_n_i) ##1
    (rd && addr_i == bcr_pkg::ADDR_CENTURY_AND_WEEKDAY) |=> !data_o[bcr_pkg::DAY_FREQ_TEST_ENABLE])
    else $error("test enable kept after power-down");
  a_idle_zero: assert property (!data_oe_o |-> data_o == 8'h00) else $error("data not zero while idle");
  a_seconds_bcd: assert property (data_oe_o && ra == bcr_pkg::ADDR_SECONDS_AND_HALT |->
    data_o[3:0] <= 4'h9 && data_o[6:4] <= 3'h5) else $error("seconds not bcd");
  a_month_zero: assert property (data_oe_o && ra == bcr_pkg::ADDR_MONTH |-> data_o[7:5] == 3'h0)
    else $error("month reserved bits set");
  a_hours_zero: assert property (data_oe_o && ra == bcr_pkg::ADDR_HOURS |-> data_o[7:6] == 2'h0)
    else $error("hours reserved bits set");
  a_weekday_zero: assert property (data_oe_o && ra == bcr_pkg::ADDR_CENTURY_AND_WEEKDAY |->
    !data_o[7] && !data_o[3]) else $error("weekday reserved bits set");
  c_read_sec: cover property (rd && addr_i == bcr_pkg::ADDR_SECONDS_AND_HALT);
  c_read_month: cover property (data_oe_o && ra == bcr_pkg::ADDR_MONTH);
  c_read_unmapped: cover property (rd && !page);
endmodule

bind bcr_clock_regs bcr_clock_regs_checker bcr_clock_regs_checker_i (.clk_i(clk_i), .resetn_i(resetn_i),
  .ce_n_i(ce_n_i), .oe_n_i(oe_n_i), .we_n_i(we_n_i), .addr_i(addr_i), .data_i(data_i),
  .osc_tick_i(osc_tick_i), .power_down_i(power_down_i), .data_o(data_o), .data_oe_o(data_oe_o));

`default_nettype wire

/* bcr_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

module bcr_host_model (
  input wire logic clk_i,        // Clock.
  input wire logic [7:0] rdat_i, // Read data from the device.
  input wire logic rdat_oe_i,    // Read data driven.
  output logic ce_n_o = 1'b1,    // Chip enable, active low.
  output logic oe_n_o = 1'b1,    // Output enable, active low.
  output logic we_n_o = 1'b1,    // Write enable, active low.
  output logic [14:0] addr_o = 15'h0000, // Address.
  output logic [7:0] wdat_o = 8'h00,     // Write data.
  output logic osc_tick_o = 1'b1,        // Oscillator runs one tick per clock.
  output logic power_down_o = 1'b0       // Power going down.
);
  // ------------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------------
  // Data is inverted after the strobe so a late sample cannot see it.
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(negedge clk_i);
    ce_n_o = 1'b0;
    we_n_o = 1'b0;
    addr_o = a;
    wdat_o = d;
    @(negedge clk_i);
    ce_n_o = 1'b1;
    we_n_o = 1'b1;
    wdat_o = ~d;
    @(negedge clk_i);
  endtask
  // Holds the read for n more cycles and counts changes of data bit zero.
  task automatic rd(input logic [14:0] a, input int n, output logic [7:0] d, output logic v, output int f);
    logic [7:0] last;
    f = 0;
    @(negedge clk_i);
    ce_n_o = 1'b0;
    oe_n_o = 1'b0;
    addr_o = a;
    @(negedge clk_i);
    d = rdat_i;
    v = rdat_oe_i;
    last = rdat_i;
    repeat (n) begin
      @(negedge clk_i);
      if (rdat_i[0] !== last[0]) f++;
      last = rdat_i;
    end
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
    @(negedge clk_i);
  endtask
  task automatic power_dip();
    @(negedge clk_i);
    power_down_o = 1'b1;
    @(negedge clk_i);
    power_down_o = 1'b0;
  endtask
endmodule

`default_nettype wire

/* bcr_clock_regs_test.sv */
`timescale 1ns/1ns
`default_nettype none

module bcr_clock_regs_test;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_n, oe_n, we_n, tick, pd, oe, v;
  logic [14:0] addr;
  logic [7:0] wd, rdat, d, y;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int rel, f;
  // Ticks run every clock, so one level of the test wave is 32 clocks.
  localparam int FLIPS = 256 / (32768 / 512 / 2);
  logic [7:0] rv [8] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  logic [7:0] mk [5] = '{8'h7f, 8'h3f, 8'h77, 8'h3f, 8'h1f};
  logic [7:0] tv [7] = '{8'h59, 8'h59, 8'h23, 8'h77, 8'h31, 8'h12, 8'h99};

  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) cyc++;

  bcr_clock_regs bcr_clock_regs_i (.clk_i(clk_i), .resetn_i(resetn_i), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .addr_i(addr), .data_i(wd), .osc_tick_i(tick), .power_down_i(pd), .data_o(rdat),
    .data_oe_o(oe));
  bcr_host_model bcr_host_model_i (.clk_i(clk_i), .rdat_i(rdat), .rdat_oe_i(oe), .ce_n_o(ce_n),
    .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(addr), .wdat_o(wd), .osc_tick_o(tick), .power_down_o(pd));

  // Without write-hold the century flag keeps its old value.
  function automatic logic [7:0] day_exp(input logic [7:0] old, input logic [7:0] w);
    return {1'b0, w[6:5], old[4], 1'b0, w[2:0]};
  endfunction
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [14:0] a, input logic [7:0] e);
    bcr_host_model_i.rd(a, 0, d, v, f);
    chk8($sformatf("register %h", a), e, d);
  endtask
  task automatic ft(input logic [7:0] e);
    bcr_host_model_i.rd(15'h7ff9, 256, d, v, f);
    chk8("test wave changes", e, 8'(f));
  endtask
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (101000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end

  initial begin
    void'($urandom(32'hf8a4429b));
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) resetn_i = 1'b1;
    for (int i = 0; i < 8; i++) rc(15'(15'h7ff8 + i), rv[i]);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      y = (i == 0) ? 8'h3f : (i == 1) ? 8'h20 : {2'b00, 6'($urandom)};
      bcr_host_model_i.wr(15'h7ff8, y);
      rc(15'h7ff8, y);
    end
    $display("test calibration field done");
    bcr_host_model_i.wr(15'h7ff8, 8'h80);
    for (int i = 0; i < 5; i++) begin
      bcr_host_model_i.wr(15'(15'h7ffa + i), 8'hff);
      rc(15'(15'h7ffa + i), mk[i]);
    end
    y = {4'($urandom % 10), 4'($urandom % 10)};
    bcr_host_model_i.wr(15'h7fff, y);
    rc(15'h7fff, y);
    for (int i = 0; i < 7; i++) bcr_host_model_i.wr(15'(15'h7ff9 + i), tv[i]);
    bcr_host_model_i.wr(15'h7ff8, 8'h00);
    rel = cyc;
    $display("test setting the clock done");
    ft(8'(FLIPS));
    bcr_host_model_i.wr(15'h7ff8, 8'h3f);
    ft(8'(FLIPS));
    bcr_host_model_i.wr(15'h7ff8, 8'h00);
    bcr_host_model_i.power_dip();
    rc(15'h7ffc, 8'h37);
    bcr_host_model_i.wr(15'h7ffc, 8'h07);
    rc(15'h7ffc, day_exp(8'h37, 8'h07));
    bcr_host_model_i.wr(15'h7ffc, 8'h27);
    rc(15'h7ffc, day_exp(8'h17, 8'h27));
    $display("test test wave and century bits done");
    wait (cyc >= rel + 32700);
    rc(15'h7ff9, 8'h59);
    wait (cyc >= rel + 32800);
    for (int i = 0; i < 8; i++) rc(15'(15'h7ff8 + i), (i == 1) ? 8'h00 : (i == 4) ? 8'h21 : rv[i]);
    $display("test century rollover done");
    bcr_host_model_i.wr(15'h7ff8, 8'h40);
    wait (cyc >= rel + 65600);
    rc(15'h7ff9, 8'h00);
    bcr_host_model_i.wr(15'h7ff8, 8'h00);
    wait (cyc >= rel + 98400);
    rc(15'h7ff9, 8'h02);
    $display("test read hold done");
    bcr_host_model_i.wr(15'h7ff9, 8'h80);
    ft(8'h00);
    rc(15'h7ff9, 8'h80);
    bcr_host_model_i.rd(15'h0123, 0, d, v, f);
    chk8("unmapped answer", 8'h00, {7'h00, v});
    $display("test halt and unmapped done");
    finish_test();
  end
endmodule

`default_nettype wire
